// ===== hdl/mmh_bus_handoff.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmh_consts.svh"
// Operation
// RULE1 - other master requests bus with one clock-wide low pulse on handoff line
// RULE2 - after accepting, processor answers with one clock-wide grant pulse, then floats
// RULE3 - master ends hold with another one clock-wide pulse on the line
// RULE4 - one exchange is exactly three pulses: request, grant, release
// RULE5 - no release at end of a memory cycle moving an odd-address word
// RULE6 - bus-exclusion output low forbids other masters taking the system bus
// RULE7 - exclusion asserted by prefix, held until following instruction completes
// RULE8 - exclusion is active low and floats during hold acknowledge
// RULE9 - queue status presented in the clock after the queue operation
// RULE10 - queue codes: 00 none, 01 first byte, 10 flush, 11 next byte
// RULE11 - outside party may decode queue status each clock to mirror queue
// RULE12 - each side drives the handoff line only during its own pulse
module mmh_bus_handoff
(
   // clock and reset
   input  wire logic                 MCLK,
   input  wire logic                 RESET_N,
   // handoff line a, open drain, low pulse active
   input  wire logic                 BUS_HANDOFF_LINE_A_I,
   output logic                      BUS_HANDOFF_LINE_A_O,
   output logic                      BUS_HANDOFF_LINE_A_OE,
   // core bus state
   input  wire logic                 CYCLE_END,
   input  wire logic                 ODD_WORD_FIRST,
   // hold state to the core
   output logic                      HOLD_ACK,
   // exclusion control from execution
   input  wire logic                 LOCK_PREFIX,
   input  wire logic                 INSTR_DONE,
   output logic                      BUS_LOCK_N_O,
   output logic                      BUS_LOCK_N_OE,
   // queue tracking
   input  wire mmh_pkg::mmh_qop_type QUEUE_OP,
   output logic                      QUEUE_STATE_HI,
   output logic                      QUEUE_STATE_LO
);
   import mmh_pkg::*;

   // pin synchroniser, first stage read only by second
   logic           line_s1_r;
   logic           line_s2_r;
   logic           line_s3_r;
   // delayed copy of our grant, lined up with its echo through the synchroniser
   logic           echo1_r;
   logic           echo2_r;
   logic           pulse_seen;
   mmh_hstate_type st_r;
   mmh_hstate_type st_nxt;
   logic           grant_drive_r;
   logic           grant_drive_nxt;
   logic           lock_r;
   logic           lock_nxt;
   logic           lock_pend_r;
   logic           lock_pend_nxt;
   logic [1:0]     qs_code;

   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         line_s1_r <= 1'b1;
         line_s2_r <= 1'b1;
         line_s3_r <= 1'b1;
         echo1_r   <= 1'b0;
         echo2_r   <= 1'b0;
      end
      else
      begin
         line_s1_r <= BUS_HANDOFF_LINE_A_I;
         line_s2_r <= line_s1_r;
         line_s3_r <= line_s2_r;
         echo1_r   <= grant_drive_r;
         echo2_r   <= echo1_r;
      end
   end

   // falling edge of the synchronised line marks a pulse from the master
   // our own grant comes back through the synchroniser two clocks later;
   // masking it keeps the grant from being read as the master's release
   assign pulse_seen = line_s3_r & ~line_s2_r & ~echo2_r; // RULE1 RULE3

   // handoff sequencer: request, grant, release
   always_comb
   begin
      st_nxt          = st_r;
      grant_drive_nxt = 1'b0;
      case (st_r)
         HO_IDLE:
         begin
            if (pulse_seen)
               st_nxt = HO_WAIT_BUS; // RULE1
         end
         HO_WAIT_BUS:
         begin
            // the first half of an odd-address word must not be split off
            if (CYCLE_END && !ODD_WORD_FIRST) // RULE5
            begin
               st_nxt          = HO_GRANT;
               grant_drive_nxt = 1'b1; // RULE2
            end
         end
         HO_GRANT:
            st_nxt = HO_HOLD; // RULE2
         HO_HOLD:
         begin
            // only the master's release pulse ends the hold
            if (pulse_seen)
               st_nxt = HO_RECLAIM; // RULE3 RULE4
         end
         HO_RECLAIM:
            st_nxt = HO_IDLE; // RULE4
         default:
            st_nxt = HO_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         st_r          <= HO_IDLE;
         grant_drive_r <= 1'b0;
      end
      else
      begin
         st_r          <= st_nxt;
         grant_drive_r <= grant_drive_nxt;
      end
   end

   // drive low only during our own grant pulse, released otherwise
   assign BUS_HANDOFF_LINE_A_O  = 1'b0;
   assign BUS_HANDOFF_LINE_A_OE = grant_drive_r; // RULE12 RULE2
   assign HOLD_ACK              = (st_r == HO_HOLD);

   // exclusion: set at prefix, armed for the next instruction's completion
   // a prefix in the same cycle as a completion wins, so the lock arms anew
   always_comb
   begin
      lock_nxt      = lock_r;
      lock_pend_nxt = lock_pend_r;
      if (LOCK_PREFIX)
      begin
         lock_nxt      = 1'b1; // RULE7
         lock_pend_nxt = 1'b1;
      end
      else if (INSTR_DONE && lock_pend_r)
      begin
         lock_nxt      = 1'b0; // RULE7
         lock_pend_nxt = 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         lock_r      <= 1'b0;
         lock_pend_r <= 1'b0;
      end
      else
      begin
         lock_r      <= lock_nxt;
         lock_pend_r <= lock_pend_nxt;
      end
   end

   // floated in hold so the borrowing master owns the line
   assign BUS_LOCK_N_O  = ~lock_r; // RULE6 RULE8
   assign BUS_LOCK_N_OE = ~HOLD_ACK; // RULE8

   mmh_queue_status u_qs
   (
      .clk      (MCLK),
      .reset_n  (RESET_N),
      .queue_op (QUEUE_OP),
      .qs_code  (qs_code)
   );

   assign QUEUE_STATE_HI = qs_code[1]; // RULE10
   assign QUEUE_STATE_LO = qs_code[0]; // RULE10

   a_grant_one_clk: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE2
      $rose(BUS_HANDOFF_LINE_A_OE) |=> !BUS_HANDOFF_LINE_A_OE)
      else $error("grant pulse wider than one clock");
   a_grant_then_hold: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE4
      BUS_HANDOFF_LINE_A_OE |=> HOLD_ACK)
      else $error("hold not entered after grant");
   a_no_odd_split: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE5
      (st_r == HO_WAIT_BUS && ODD_WORD_FIRST) |=> !BUS_HANDOFF_LINE_A_OE)
      else $error("bus released inside odd word");
   a_no_drive_hold: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE12
      HOLD_ACK |-> !BUS_HANDOFF_LINE_A_OE)
      else $error("line driven outside grant pulse");
   a_lock_float: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE8
      HOLD_ACK |-> !BUS_LOCK_N_OE)
      else $error("lock driven in hold");
   a_lock_on_prefix: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE7
      LOCK_PREFIX |=> !BUS_LOCK_N_O)
      else $error("lock not asserted after prefix");
   a_lock_release: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE7
      (INSTR_DONE && lock_pend_r && !LOCK_PREFIX) |=> BUS_LOCK_N_O)
      else $error("lock stuck after instruction");
   a_release_idle: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE3
      (HOLD_ACK && pulse_seen) |=> ##1 (st_r == HO_IDLE))
      else $error("hold not ended by release pulse");

   // handoff and exclusion checks beyond the basic handshake
   a_grant_not_release: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE4
      $rose(BUS_HANDOFF_LINE_A_OE) |=> HOLD_ACK [*3])
      else $error("own grant pulse ended the hold");
   a_hold_after_grant: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE2
      $rose(HOLD_ACK) |-> $past(BUS_HANDOFF_LINE_A_OE))
      else $error("hold entered without grant pulse");
   a_idle_no_drive: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE12
      (st_r == HO_IDLE) |-> !BUS_HANDOFF_LINE_A_OE)
      else $error("line driven while idle");
   a_lock_kept: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE7
      (!BUS_LOCK_N_O && !INSTR_DONE) |=> !BUS_LOCK_N_O)
      else $error("lock dropped before instruction end");
endmodule
`default_nettype wire

// ===== hdl/mmh_consts.svh
`ifndef MMH_CONSTS_SVH
`define MMH_CONSTS_SVH
// queue status codes
`define MMH_QS_NONE    2'h0
`define MMH_QS_FIRST   2'h1
`define MMH_QS_FLUSH   2'h2
`define MMH_QS_NEXT    2'h3
// handoff pulse width and pulse count per exchange
`define MMH_PULSE_CLKS 1
`define MMH_PULSES     3
// reset values
`define MMH_QS_RESET   2'h0
`endif

// ===== hdl/mmh_pkg.sv
package mmh_pkg;
   typedef enum logic [2:0] {
      HO_IDLE,
      HO_WAIT_BUS,
      HO_GRANT,
      HO_HOLD,
      HO_RECLAIM
   } mmh_hstate_type;
   typedef enum logic [1:0] {
      QOP_NONE,
      QOP_FIRST,
      QOP_FLUSH,
      QOP_NEXT
   } mmh_qop_type;
endpackage

// ===== hdl/mmh_queue_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmh_consts.svh"
module mmh_queue_status
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   // queue operation of this cycle
   input  wire mmh_pkg::mmh_qop_type queue_op,
   // registered status code
   output logic [1:0]                qs_code
);
   import mmh_pkg::*;

   logic [1:0] qs_r;
   logic [1:0] qs_nxt;

   // code follows the operation by one cycle, so it is valid in the next clock
   always_comb
   begin
      case (queue_op)
         QOP_FIRST: qs_nxt = `MMH_QS_FIRST; // RULE10
         QOP_FLUSH: qs_nxt = `MMH_QS_FLUSH; // RULE10
         QOP_NEXT:  qs_nxt = `MMH_QS_NEXT;  // RULE10
         default:   qs_nxt = `MMH_QS_NONE;  // RULE10
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         qs_r <= `MMH_QS_RESET;
      else
         qs_r <= qs_nxt; // RULE9
   end

   assign qs_code = qs_r;

   a_qs_follows_op: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
      (queue_op == QOP_NONE) |=> (qs_code == `MMH_QS_NONE))
      else $error("queue status not idle after no-op");
   a_qs_flush_code: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
      (queue_op == QOP_FLUSH) |=> (qs_code == `MMH_QS_FLUSH))
      else $error("flush code missing");
   a_qs_first_code: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
      (queue_op == QOP_FIRST) |=> (qs_code == `MMH_QS_FIRST))
      else $error("first byte code missing");
   a_qs_next_code: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
      (queue_op == QOP_NEXT) |=> (qs_code == `MMH_QS_NEXT))
      else $error("subsequent byte code missing");
endmodule
`default_nettype wire

// ===== verification/mmh_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmh_master_model
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // bench commands, one cycle each
   input  wire logic req_go,
   input  wire logic rel_go,
   // line level and our pull-down
   input  wire logic line_lvl,
   output logic      pull
);
   // pulse only onto an idle line, so we never fight the grant
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         pull <= 1'b0;
      else
         pull <= (req_go | rel_go) & line_lvl;
   end
endmodule
`default_nettype wire

// ===== verification/max_mode_bus_handoff_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module max_mode_bus_handoff_status_bench;
   import mmh_pkg::*;
   logic        clk, reset_n, req_go, rel_go, pull, line_lvl;
   logic        cyc_end, odd_first, lock_pre, instr_done;
   mmh_qop_type q_op;
   logic        oe, o, hold_ack, lock_n, lock_oe, qs_hi, qs_lo;
   int          error_cnt, cmp_count, cyc, k;
   // open-drain line with pull-up
   assign line_lvl = !((oe & !o) | pull);
   mmh_bus_handoff u_mmh_bus_handoff (.MCLK(clk), .RESET_N(reset_n),
      .BUS_HANDOFF_LINE_A_I(line_lvl), .BUS_HANDOFF_LINE_A_O(o),
      .BUS_HANDOFF_LINE_A_OE(oe), .CYCLE_END(cyc_end), .ODD_WORD_FIRST(odd_first),
      .HOLD_ACK(hold_ack), .LOCK_PREFIX(lock_pre), .INSTR_DONE(instr_done),
      .BUS_LOCK_N_O(lock_n), .BUS_LOCK_N_OE(lock_oe), .QUEUE_OP(q_op),
      .QUEUE_STATE_HI(qs_hi), .QUEUE_STATE_LO(qs_lo));
   mmh_master_model u_mmh_master_model (.clk(clk), .reset_n(reset_n),
      .req_go(req_go), .rel_go(rel_go), .line_lvl(line_lvl), .pull(pull));
   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task summarize;
   begin
      if (error_cnt == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   task chk(input logic [1:0] got, input logic [1:0] exp);
   begin
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // request, odd-word deferral, grant, hold, release
   task t_handoff;
   begin
      @(posedge clk) req_go <= 1'b1;
      @(posedge clk) req_go <= 1'b0;
      repeat (5) @(posedge clk);
      cyc_end <= 1'b1;
      odd_first <= 1'b1;
      @(posedge clk) cyc_end <= 1'b0;
      odd_first <= 1'b0;
      repeat (3)
      begin
         @(posedge clk);
         #1 chk({oe, hold_ack}, 2'h0);
      end
      @(posedge clk) cyc_end <= 1'b1;
      @(posedge clk) cyc_end <= 1'b0;
      #1 chk({oe, line_lvl}, 2'h2);
      @(posedge clk);
      #1 chk({oe, hold_ack}, 2'h1);
      chk({1'b0, lock_oe}, 2'h0);
      repeat (3) @(posedge clk);
      #1 chk({oe, hold_ack}, 2'h1);
      @(posedge clk) rel_go <= 1'b1;
      @(posedge clk) rel_go <= 1'b0;
      k = 0;
      while (hold_ack !== 1'b0 && k < 8)
      begin
         @(posedge clk);
         #1 k++;
      end
      chk({oe, hold_ack}, 2'h0);
   end
   endtask
   // lock held from prefix until next instruction ends
   task t_lock;
   begin
      @(posedge clk) lock_pre <= 1'b1;
      @(posedge clk) lock_pre <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk({lock_oe, lock_n}, 2'h2);
      @(posedge clk) instr_done <= 1'b1;
      @(posedge clk) instr_done <= 1'b0;
      @(posedge clk);
      #1 chk({lock_oe, lock_n}, 2'h3);
   end
   endtask
   // every queue code, one cycle late
   task t_queue;
   begin
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk) q_op <= mmh_qop_type'(i);
         @(posedge clk) q_op <= QOP_NONE;
         #1 chk({qs_hi, qs_lo}, 2'(i));
         @(posedge clk);
         #1 chk({qs_hi, qs_lo}, 2'h0);
      end
   end
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 1000)
      begin
         error_cnt++;
         summarize;
      end
   end
   // main sequence
   initial
   begin
      {reset_n, req_go, rel_go, cyc_end, odd_first, lock_pre, instr_done} = '0;
      q_op = QOP_NONE;
      error_cnt = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      t_handoff;
      t_lock;
      t_queue;
      summarize;
   end
endmodule
`default_nettype wire
